// ==== logic/tbc_timer.sv ====
// 16-bit capture/compare timer: counter, modes, flag and registers
//
// Contract
// - single-shot with edge setting 1 starts on either event edge.
// - capture events accepted only while event input enable is set.
// - interrupt enable bit 0 at 0x05 enables the capture request.
// - flag set by mode condition; writing one clears it.
// - in capture modes reading the capture register clears the flag.
// - periodic, time-out, single-shot set flag when counter reaches top.
// - capture-on-event loads counter into capture register, sets flag.
// - frequency mode edge loads capture, restarts counter, sets flag.
// - pulse-width mode: one edge restarts, opposite edge captures and flags.
// - combined mode stops counter and flags on second active edge.
// - 8-bit PWM sets flag when counter reaches low compare byte.
// - status bit 0 shows running; read-only, writes ignored.
// - debug-run 0 halts timer and ignores events in break; 1 runs.
// - one shared temp byte at 0x09 buffers 16-bit accesses, also direct.
// - counter low byte at 0x0A, high byte one above.
// - a bus write to the counter beats an internal update.
// - capture register at 0x0C holds counter sampled at capture.
// - in top-value modes capture register is the wrap or end value.
// - in 8-bit PWM the compare bytes are independent registers.
// - mode field codes 0x0 periodic to 0x6 single-shot, 0x7 PWM.
`timescale 1ns/1ns
module tbc_timer (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // byte register port
  input  wire logic [3:0]           bus_addr,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  input  wire logic [7:0]           bus_wdata,
  output logic [7:0]                bus_rdata,
  // configuration from the control registers
  input  wire logic                 timer_enable,
  input  wire logic [2:0]           count_mode_sel,
  input  wire logic                 event_edge,
  // event and debug
  input  wire logic                 event_in,
  input  wire logic                 cpu_halted,
  // interrupt request
  output logic                      snapshot_irq
);
  import tbc_pkg::*;

  // ==========================================================
  // state
  logic        evt_en_r;
  logic        irq_en_r;
  logic        flag_r;
  logic        run_r;
  logic        run_nxt;
  logic        dbg_run_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] match_snapshot_value_r;
  logic [7:0]  rdata_r;
  logic [7:0]  temp;
  logic [7:0]  rd_mux;
  logic        cap_ld;
  logic        hit;
  tbc_fpw_t    fpw_r;
  tbc_fpw_t    fpw_nxt;

  // ==========================================================
  // address decode
  wire wr_evt   = bus_wr & (bus_addr == OFS_EVT_CTRL);
  wire wr_ien   = bus_wr & (bus_addr == OFS_IRQ_EN);
  wire wr_flag  = bus_wr & (bus_addr == OFS_IRQ_FLAG);
  wire wr_dbg   = bus_wr & (bus_addr == OFS_DBG_CTRL);
  wire wr_temp  = bus_wr & (bus_addr == OFS_TEMP);
  wire wr_cnt_l = bus_wr & (bus_addr == OFS_CNT_LO);
  wire wr_cnt_h = bus_wr & (bus_addr == OFS_CNT_HI);
  wire wr_cc_l  = bus_wr & (bus_addr == OFS_MATCH_SNAPSHOT_VALUE_LO);
  wire wr_cc_h  = bus_wr & (bus_addr == OFS_MATCH_SNAPSHOT_VALUE_HI);
  wire rd_cnt_l = bus_rd & (bus_addr == OFS_CNT_LO);
  wire rd_cc_l  = bus_rd & (bus_addr == OFS_MATCH_SNAPSHOT_VALUE_LO);

  // mode decode
  wire is_pwm   = (count_mode_sel == MODE_PWM8);
  wire is_snapshot_irq  = (count_mode_sel >= MODE_SNAPSHOT_IRQ_EVT) & (count_mode_sel <= MODE_SNAPSHOT_IRQ_FPW);
  wire pwm_rd   = is_pwm & rd_cc_l;

  // event qualification: halted in break unless debug-run set
  wire halt_w   = cpu_halted & ~dbg_run_r;
  wire tick     = run_r & ~halt_w & timer_enable;
  wire ev_ok    = timer_enable & evt_en_r & ~halt_w;
  wire ev_rise;
  wire ev_fall;
  wire pos_ev   = ev_ok & ev_rise;
  wire neg_ev   = ev_ok & ev_fall;
  wire act_ev   = event_edge ? neg_ev : pos_ev;
  wire opp_ev   = event_edge ? pos_ev : neg_ev;
  wire any_ev   = pos_ev | neg_ev;

  // top comparisons
  wire top16    = (cnt_r == match_snapshot_value_r);
  wire top8     = (cnt_r[7:0] == match_snapshot_value_r[7:0]);
  wire [15:0] cnt_inc = cnt_r + CNT_ONE;

  // ==========================================================
  // submodules
  tbc_edge_det u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sig     (event_in),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  tbc_wide_temp u_temp (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .wr_direct   (wr_temp),
    .wr_low      (wr_cnt_l | (wr_cc_l & ~is_pwm)),
    .wdata       (bus_wdata),
    .rd_cnt_low  (rd_cnt_l),
    .rd_match_snapshot_value_low (rd_cc_l & ~is_pwm),
    .cnt_hi      (cnt_r[15:8]),
    .match_snapshot_value_hi     (match_snapshot_value_r[15:8]),
    .temp        (temp)
  );

  // ==========================================================
  // counter next value per mode
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    fpw_nxt = FPW_IDLE;
    cap_ld  = 1'b0;
    hit     = 1'b0;
    if (!timer_enable) begin
      run_nxt = 1'b0;
    end else begin
      unique case (count_mode_sel)
        MODE_PERIODIC: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = top16 ? RST_WORD : cnt_inc;
            hit     = top16;
          end
        end
        MODE_TIMEOUT: begin
          if (act_ev) begin
            run_nxt = 1'b1;
            cnt_nxt = RST_WORD;
          end else if (opp_ev) begin
            run_nxt = 1'b0;
          end else if (tick) begin
            cnt_nxt = top16 ? RST_WORD : cnt_inc;
            hit     = top16;
          end
        end
        MODE_SNAPSHOT_IRQ_EVT: begin
          run_nxt = 1'b1;
          cap_ld  = act_ev;
          hit     = act_ev;
          if (tick) begin
            cnt_nxt = cnt_inc;
          end
        end
        MODE_SNAPSHOT_IRQ_FRQ: begin
          run_nxt = 1'b1;
          cap_ld  = act_ev;
          hit     = act_ev;
          if (act_ev) begin
            cnt_nxt = RST_WORD;
          end else if (tick) begin
            cnt_nxt = cnt_inc;
          end
        end
        MODE_SNAPSHOT_IRQ_PW: begin
          run_nxt = 1'b1;
          cap_ld  = opp_ev;
          hit     = opp_ev;
          if (act_ev) begin
            cnt_nxt = RST_WORD;
          end else if (tick) begin
            cnt_nxt = cnt_inc;
          end
        end
        MODE_SNAPSHOT_IRQ_FPW: begin
          fpw_nxt = fpw_r;
          if (tick) begin
            cnt_nxt = cnt_inc;
          end
          unique case (fpw_r)
            FPW_IDLE: begin
              run_nxt = 1'b0;
              if (act_ev) begin
                run_nxt = 1'b1;
                cnt_nxt = RST_WORD;
                fpw_nxt = FPW_ARMED;
              end
            end
            FPW_ARMED: begin
              if (opp_ev) begin
                cap_ld  = 1'b1;
                fpw_nxt = FPW_SECOND;
              end
            end
            FPW_SECOND: begin
              if (act_ev) begin
                run_nxt = 1'b0;
                hit     = 1'b1;
                cnt_nxt = cnt_r;
                fpw_nxt = FPW_IDLE;
              end
            end
          endcase
        end
        MODE_SINGLE: begin
          if (tick) begin
            hit     = top16;
            run_nxt = ~top16;
            cnt_nxt = top16 ? RST_WORD : cnt_inc;
          end else if (!run_r && (event_edge ? any_ev : pos_ev)) begin
            run_nxt = 1'b1;
            cnt_nxt = RST_WORD;
          end
        end
        MODE_PWM8: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = top8 ? RST_WORD : {8'h00, cnt_inc[7:0]};
            hit     = top8;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // counter and run state; bus write beats internal update
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= RST_WORD;
      run_r <= 1'b0;
      fpw_r <= FPW_IDLE;
    end else begin
      cnt_r <= wr_cnt_h ? {bus_wdata, temp} : cnt_nxt;
      run_r <= run_nxt;
      fpw_r <= fpw_nxt;
    end
  end

  // capture/compare next value
  wire [15:0] match_snapshot_value_nxt =
    (is_pwm & wr_cc_l) ? {match_snapshot_value_r[15:8], bus_wdata} :
    (is_pwm & wr_cc_h) ? {bus_wdata, match_snapshot_value_r[7:0]}  :
    wr_cc_h            ? {bus_wdata, temp}         :
    cap_ld             ? cnt_r                     : match_snapshot_value_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_snapshot_value_r <= RST_WORD;
    end else begin
      match_snapshot_value_r <= match_snapshot_value_nxt;
    end
  end

  // ==========================================================
  // flag: set beats clear
  wire flag_clr = (wr_flag & bus_wdata[BIT_IRQ]) | (is_snapshot_irq & rd_cc_l);
  wire flag_nxt = hit | (flag_r & ~flag_clr);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // control bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_r  <= 1'b0;
      irq_en_r  <= 1'b0;
      dbg_run_r <= 1'b0;
    end else begin
      evt_en_r  <= wr_evt ? bus_wdata[BIT_EVT_EN] : evt_en_r;
      irq_en_r  <= wr_ien ? bus_wdata[BIT_IRQ] : irq_en_r;
      dbg_run_r <= wr_dbg ? bus_wdata[BIT_DBG_RUN] : dbg_run_r;
    end
  end

  assign snapshot_irq = flag_r & irq_en_r;

  // ==========================================================
  // read mux; high bytes come from temp except in PWM compare
  always_comb begin
    rd_mux = RST_BYTE;
    unique case (bus_addr)
      OFS_EVT_CTRL: rd_mux = {7'h00, evt_en_r};
      OFS_IRQ_EN:   rd_mux = {7'h00, irq_en_r};
      OFS_IRQ_FLAG: rd_mux = {7'h00, flag_r};
      OFS_STATE:    rd_mux = {7'h00, run_r};
      OFS_DBG_CTRL: rd_mux = {7'h00, dbg_run_r};
      OFS_TEMP:     rd_mux = temp;
      OFS_CNT_LO:   rd_mux = cnt_r[7:0];
      OFS_CNT_HI:   rd_mux = temp;
      OFS_MATCH_SNAPSHOT_VALUE_LO:  rd_mux = match_snapshot_value_r[7:0];
      OFS_MATCH_SNAPSHOT_VALUE_HI:  rd_mux = is_pwm ? match_snapshot_value_r[15:8] : temp;
      default:      rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RST_BYTE;
    end else begin
      rdata_r <= bus_rd ? rd_mux : rdata_r;
    end
  end

  assign bus_rdata = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_single_trig;
    timer_enable && (count_mode_sel == MODE_SINGLE) && !run_r && event_edge && any_ev;
  endsequence
  sequence s_fpw_second;
    (fpw_r == FPW_SECOND) && (count_mode_sel == MODE_SNAPSHOT_IRQ_FPW) && timer_enable && act_ev;
  endsequence

  a_single_both_edges: assert property (s_single_trig |=> run_r)
    else $error("single shot did not start on event");
  a_event_gate: assert property (cap_ld |-> evt_en_r && !halt_w)
    else $error("capture taken with events disabled");
  a_irq_output: assert property (snapshot_irq == (flag_r && irq_en_r))
    else $error("interrupt request mismatch");
  a_flag_set: assert property (hit |=> flag_r)
    else $error("flag not set on event");
  a_flag_w1c: assert property (wr_flag && bus_wdata[0] && !hit |=> !flag_r)
    else $error("flag not cleared by write");
  a_read_clears: assert property (is_snapshot_irq && rd_cc_l && !hit |=> !flag_r)
    else $error("capture read did not clear flag");
  a_periodic_wrap: assert property ((count_mode_sel == MODE_PERIODIC) && tick && top16
    && !wr_cnt_h |=> (cnt_r == RST_WORD) && flag_r)
    else $error("periodic wrap wrong");
  a_capture_value: assert property (cap_ld && !wr_cc_h && !wr_cc_l
    |=> match_snapshot_value_r == $past(cnt_r))
    else $error("capture value wrong");
  a_fpw_stop: assert property (s_fpw_second |=> !run_r && flag_r ##1 !run_r)
    else $error("combined mode did not stop");
  a_pwm_hit: assert property (is_pwm && tick && top8 && !wr_cnt_h |=> flag_r
    && cnt_r[7:0] == 8'h00)
    else $error("pwm match wrong");
  a_status_read: assert property (bus_rd && bus_addr == OFS_STATE |=> bus_rdata[0]
    == $past(run_r))
    else $error("status read wrong");
  a_halt_freeze: assert property (halt_w && !wr_cnt_h |=> cnt_r == $past(cnt_r))
    else $error("counter moved in break");
  a_cnt_write_wins: assert property (wr_cnt_h |=> cnt_r == {$past(bus_wdata),
    $past(temp)})
    else $error("counter write lost");

endmodule

// ==== logic/tbc_pkg.sv ====
// shared constants for the capture/compare timer register block
package tbc_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [3:0] OFS_EVT_CTRL  = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN    = 4'h5;
  localparam logic [3:0] OFS_IRQ_FLAG  = 4'h6;
  localparam logic [3:0] OFS_STATE     = 4'h7;
  localparam logic [3:0] OFS_DBG_CTRL  = 4'h8;
  localparam logic [3:0] OFS_TEMP      = 4'h9;
  localparam logic [3:0] OFS_CNT_LO    = 4'hA;
  localparam logic [3:0] OFS_CNT_HI    = 4'hB;
  localparam logic [3:0] OFS_MATCH_SNAPSHOT_VALUE_LO   = 4'hC;
  localparam logic [3:0] OFS_MATCH_SNAPSHOT_VALUE_HI   = 4'hD;

  // ==========================================================
  // field positions
  localparam int BIT_EVT_EN   = 0;
  localparam int BIT_IRQ      = 0;
  localparam int BIT_RUN      = 0;
  localparam int BIT_DBG_RUN  = 0;

  // ==========================================================
  // reset values and counter step
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // ==========================================================
  // counting mode codes
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT  = 3'h1;
  localparam logic [2:0] MODE_SNAPSHOT_IRQ_EVT = 3'h2;
  localparam logic [2:0] MODE_SNAPSHOT_IRQ_FRQ = 3'h3;
  localparam logic [2:0] MODE_SNAPSHOT_IRQ_PW  = 3'h4;
  localparam logic [2:0] MODE_SNAPSHOT_IRQ_FPW = 3'h5;
  localparam logic [2:0] MODE_SINGLE   = 3'h6;
  localparam logic [2:0] MODE_PWM8     = 3'h7;

  // combined frequency and pulse-width sequencer
  typedef enum logic [1:0] {
    FPW_IDLE,
    FPW_ARMED,
    FPW_SECOND
  } tbc_fpw_t;

endpackage

// ==== logic/tbc_edge_det.sv ====
// rising and falling edge detector for the event input
`timescale 1ns/1ns
module tbc_edge_det (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // event level and edges
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  import tbc_pkg::*;

  logic prev_r;

  // ==========================================================
  // previous level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sig;
    end
  end

  // edges relative to last cycle
  assign rise = sig & ~prev_r;
  assign fall = ~sig & prev_r;

endmodule

// ==== logic/tbc_wide_temp.sv ====
// shared temporary byte for atomic 16-bit register access
`timescale 1ns/1ns
module tbc_wide_temp (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // load sources
  input  wire logic       wr_direct,
  input  wire logic       wr_low,
  input  wire logic [7:0] wdata,
  input  wire logic       rd_cnt_low,
  input  wire logic       rd_match_snapshot_value_low,
  input  wire logic [7:0] cnt_hi,
  input  wire logic [7:0] match_snapshot_value_hi,
  // held byte
  output logic [7:0]      temp
);
  import tbc_pkg::*;

  logic [7:0] temp_r;
  logic [7:0] temp_nxt;

  // ==========================================================
  // low-byte reads park the high byte, low-byte writes park data
  assign temp_nxt = (wr_direct | wr_low) ? wdata      :
                    rd_cnt_low           ? cnt_hi     :
                    rd_match_snapshot_value_low          ? match_snapshot_value_hi    : temp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      temp_r <= RST_BYTE;
    end else begin
      temp_r <= temp_nxt;
    end
  end

  assign temp = temp_r;

endmodule

// ==== sim/tbc_timer_tb.sv ====
// self-checking bench for the capture/compare timer register block
`timescale 1ns/1ns
module testbench;
  import tbc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic       clk_sys;
  logic       rst_n;
  logic [3:0] bus_addr;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic       timer_enable;
  logic [2:0] count_mode_sel;
  logic       event_edge;
  logic       event_in;
  logic       cpu_halted;
  logic       snapshot_irq;
  logic [7:0] rd_byte;
  int         n_mismatch;
  int         checks_done;

  // device under test
  tbc_timer tbc_timer_inst (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .bus_addr       (bus_addr),
    .bus_wr         (bus_wr),
    .bus_rd         (bus_rd),
    .bus_wdata      (bus_wdata),
    .bus_rdata      (bus_rdata),
    .timer_enable   (timer_enable),
    .count_mode_sel (count_mode_sel),
    .event_edge     (event_edge),
    .event_in       (event_in),
    .cpu_halted     (cpu_halted),
    .snapshot_irq   (snapshot_irq)
  );

  // ==========================================================
  // clock, 100 ns period
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ==========================================================
  // bus and compare helpers, drives land 10 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    cyc(1);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    cyc(1);
    bus_wr    = 1'b0;
  endtask
  task automatic bus_read(input logic [3:0] a);
    cyc(1);
    bus_addr = a;
    bus_rd   = 1'b1;
    cyc(1);
    bus_rd   = 1'b0;
    rd_byte  = bus_rdata;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    bus_write(a, v[7:0]);
    bus_write(a + 4'h1, v[15:8]);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    bus_read(a);
    chk8(rd_byte, exp);
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (snapshot_irq !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    chk1(snapshot_irq, 1'b1);
  endtask
  task automatic ev(input logic v);
    cyc(1);
    event_in = v;
    cyc(1);
  endtask
  task automatic cfg(input logic [2:0] m, input logic e, input logic en);
    cyc(1);
    count_mode_sel = m;
    event_edge     = e;
    timer_enable   = en;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 4; i < 14; i++) expect_reg(4'(i), RST_BYTE);
    expect_reg(4'h0, 8'h00);
    expect_reg(4'hF, 8'h00);
    chk1(snapshot_irq, 1'b0);
  endtask
  task automatic t_regs();
    bus_write(OFS_STATE, 8'hFF);
    expect_reg(OFS_STATE, 8'h00);
    bus_write(OFS_TEMP, 8'hA5);
    expect_reg(OFS_TEMP, 8'hA5);
    wr16(OFS_CNT_LO, 16'h1234);
    expect_reg(OFS_CNT_LO, 8'h34);
    expect_reg(OFS_CNT_HI, 8'h12);
    expect_reg(OFS_TEMP, 8'h12);
    bus_write(OFS_TEMP, 8'h77);
    bus_write(OFS_CNT_HI, 8'h56);
    expect_reg(OFS_CNT_LO, 8'h77);
    expect_reg(OFS_CNT_HI, 8'h56);
  endtask
  task automatic t_periodic();
    wr16(OFS_CNT_LO, RST_WORD);
    wr16(OFS_MATCH_SNAPSHOT_VALUE_LO, 16'h0005);
    bus_write(OFS_IRQ_EN, 8'h01);
    expect_reg(OFS_IRQ_EN, 8'h01);
    cfg(MODE_PERIODIC, 1'b0, 1'b1);
    wait_irq();
    expect_reg(OFS_STATE, 8'h01);
    timer_enable = 1'b0;
    bus_write(OFS_IRQ_EN, 8'h00);
    chk1(snapshot_irq, 1'b0);
    bus_write(OFS_IRQ_EN, 8'h01);
    chk1(snapshot_irq, 1'b1);
    bus_write(OFS_IRQ_FLAG, 8'h01);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
    chk1(snapshot_irq, 1'b0);
  endtask
  task automatic t_collide();
    wr16(OFS_MATCH_SNAPSHOT_VALUE_LO, 16'hFFFF);
    cfg(MODE_PERIODIC, 1'b0, 1'b1);
    cyc(3);
    wr16(OFS_CNT_LO, 16'h2000);
    timer_enable = 1'b0;
    bus_read(OFS_CNT_LO);
    expect_reg(OFS_CNT_HI, 8'h20);
  endtask
  task automatic t_debug();
    cpu_halted = 1'b1;
    cfg(MODE_PERIODIC, 1'b0, 1'b1);
    wr16(OFS_CNT_LO, 16'h0100);
    cyc(5);
    expect_reg(OFS_CNT_LO, 8'h00);
    expect_reg(OFS_CNT_HI, 8'h01);
    bus_write(OFS_DBG_CTRL, 8'h01);
    expect_reg(OFS_DBG_CTRL, 8'h01);
    cyc(4);
    bus_read(OFS_CNT_LO);
    chk1(rd_byte != 8'h00, 1'b1);
    bus_write(OFS_DBG_CTRL, 8'h00);
    bus_write(OFS_EVT_CTRL, 8'h01);
    cfg(MODE_SNAPSHOT_IRQ_EVT, 1'b0, 1'b1);
    ev(1'b1);
    ev(1'b0);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
    cpu_halted = 1'b0;
  endtask
  task automatic t_capture();
    bus_write(OFS_EVT_CTRL, 8'h00);
    ev(1'b1);
    ev(1'b0);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
    bus_write(OFS_EVT_CTRL, 8'h01);
    wr16(OFS_CNT_LO, 16'h0ABC);
    ev(1'b1);
    expect_reg(OFS_IRQ_FLAG, 8'h01);
    // counter ran one count between the write and the edge
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_LO, 8'hBD);
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_HI, 8'h0A);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
    ev(1'b0);
  endtask
  task automatic t_freq_pw();
    // timer stays enabled, so captures see one count after each write
    cfg(MODE_SNAPSHOT_IRQ_FRQ, 1'b0, 1'b1);
    wr16(OFS_CNT_LO, 16'h0077);
    ev(1'b1);
    expect_reg(OFS_CNT_LO, 8'h01);
    expect_reg(OFS_IRQ_FLAG, 8'h01);
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_LO, 8'h78);
    ev(1'b0);
    cfg(MODE_SNAPSHOT_IRQ_PW, 1'b1, 1'b1);
    wr16(OFS_CNT_LO, 16'h0033);
    ev(1'b1);
    expect_reg(OFS_IRQ_FLAG, 8'h01);
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_LO, 8'h34);
    wr16(OFS_CNT_LO, 16'h0044);
    ev(1'b0);
    expect_reg(OFS_CNT_LO, 8'h01);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
  endtask
  task automatic t_fpw_timeout();
    cfg(MODE_SNAPSHOT_IRQ_FPW, 1'b0, 1'b1);
    ev(1'b1);
    expect_reg(OFS_STATE, 8'h01);
    ev(1'b0);
    expect_reg(OFS_IRQ_FLAG, 8'h00);
    ev(1'b1);
    expect_reg(OFS_IRQ_FLAG, 8'h01);
    expect_reg(OFS_STATE, 8'h00);
    bus_read(OFS_MATCH_SNAPSHOT_VALUE_LO);
    ev(1'b0);
    cfg(MODE_TIMEOUT, 1'b0, 1'b1);
    wr16(OFS_MATCH_SNAPSHOT_VALUE_LO, 16'hFFFF);
    ev(1'b1);
    expect_reg(OFS_STATE, 8'h01);
    ev(1'b0);
    expect_reg(OFS_STATE, 8'h00);
  endtask
  task automatic t_single();
    cfg(MODE_SINGLE, 1'b1, 1'b1);
    wr16(OFS_MATCH_SNAPSHOT_VALUE_LO, 16'h0040);
    for (int i = 0; i < 2; i++) begin
      bus_write(OFS_IRQ_FLAG, 8'h01);
      ev(i == 0);
      expect_reg(OFS_STATE, 8'h01);
      wait_irq();
      expect_reg(OFS_STATE, 8'h00);
    end
    bus_write(OFS_IRQ_FLAG, 8'h01);
  endtask
  task automatic t_pwm8();
    cfg(MODE_PWM8, 1'b0, 1'b0);
    bus_write(OFS_TEMP, 8'h55);
    bus_write(OFS_MATCH_SNAPSHOT_VALUE_HI, 8'h80);
    bus_write(OFS_MATCH_SNAPSHOT_VALUE_LO, 8'h03);
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_HI, 8'h80);
    expect_reg(OFS_MATCH_SNAPSHOT_VALUE_LO, 8'h03);
    wr16(OFS_CNT_LO, RST_WORD);
    timer_enable = 1'b1;
    wait_irq();
    timer_enable = 1'b0;
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    n_mismatch     = 0;
    checks_done    = 0;
    rst_n          = 1'b0;
    bus_addr       = 4'h0;
    bus_wr         = 1'b0;
    bus_rd         = 1'b0;
    bus_wdata      = 8'h00;
    timer_enable   = 1'b0;
    count_mode_sel = MODE_PERIODIC;
    event_edge     = 1'b0;
    event_in       = 1'b0;
    cpu_halted     = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_periodic();
    t_collide();
    t_debug();
    t_capture();
    t_freq_pw();
    t_fpw_timeout();
    t_single();
    t_pwm8();
    wrap_up();
  end
endmodule
